/* hdl/iapf_top.sv */
// Purpose: In-application programming control registers and sequencer
// Assumes: Register port and flash macro run on core_clk_i
// Notes: Flash array timing is modelled by cycle counters only
`timescale 1ns/1ps
`include "iapf_regs.svh"
module iapf_top #(
  parameter int unsigned UNLOCK_CYCLES = `IAPF_UNLOCK_CYCLES,
  parameter int unsigned PROG_CYCLES = `IAPF_PROG_CYCLES
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Register port
  input wire logic [3:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  // CPU
  output logic cpu_stall_o,
  // Flash macro
  output logic flash_start_o,
  output logic [2:0] flash_mode_o,
  output logic [12:0] flash_addr_o,
  input wire logic [15:0] flash_rdata_i,
  input wire logic [4:0] flash_wbuf_idx_i,
  output logic [15:0] flash_wbuf_data_o
);
  // ************************************************
  // Declarations
  // ************************************************
  iapf_pkg::iapf_state_e state_r;
  iapf_pkg::iapf_cnt_t op_cnt_r;
  logic [7:0] addr_lo_r;
  logic [4:0] addr_hi_r;
  logic [7:0] dlo_r [4];
  logic [7:0] dhi_r [4];
  logic ew_en_r;
  logic [2:0] mode_r;
  logic trig_r;
  logic wi_r;
  logic re_r;
  logic ri_r;
  logic bclr_r;
  logic bclr_rsv7_r;
  logic bclr_rsv4_r;
  logic wr_ok;
  logic ctrl_wr;
  logic triple;
  logic allow_w;
  logic allow_r;
  logic go_prog;
  logic drop_wi;
  logic go_read;
  logic drop_ri;
  logic prog_done;
  logic read_done;
  logic wb_wr_en;
  logic [4:0] wb_wr_idx;
  logic [15:0] wb_wr_data;
  logic wb_clr;
  logic [12:0] word_addr;
  logic unl_done;
  logic unl_pass;

  iapf_unlock_if unl_if ();

  // ************************************************
  // Decode and sequencing terms
  // ************************************************
  // Writes while busy are dropped; the CPU is stalled then anyway
  assign wr_ok = sfr_wr_i && (state_r == iapf_pkg::ST_IDLE);
  assign ctrl_wr = wr_ok && (sfr_addr_i == `IAPF_OFF_CTRL);
  assign triple = sfr_wdata_i[`IAPF_CTRL_WI] && sfr_wdata_i[`IAPF_CTRL_RE] && sfr_wdata_i[`IAPF_CTRL_RI];
  assign allow_w = ew_en_r && ((mode_r == iapf_pkg::MODE_WRITE) || (mode_r == iapf_pkg::MODE_ERASE));
  assign allow_r = re_r && (mode_r == iapf_pkg::MODE_READ);
  assign go_prog = (state_r == iapf_pkg::ST_IDLE) && wi_r && allow_w;
  assign drop_wi = (state_r == iapf_pkg::ST_IDLE) && wi_r && !allow_w;
  assign go_read = (state_r == iapf_pkg::ST_IDLE) && !wi_r && ri_r && allow_r;
  assign drop_ri = (state_r == iapf_pkg::ST_IDLE) && !wi_r && ri_r && !allow_r;
  assign prog_done = (state_r == iapf_pkg::ST_PROG) && (op_cnt_r == iapf_pkg::iapf_cnt_t'(PROG_CYCLES - 1));
  assign read_done = (state_r == iapf_pkg::ST_READ) && (op_cnt_r == iapf_pkg::iapf_cnt_t'(`IAPF_READ_CYCLES - 1));
  assign word_addr = {addr_hi_r, addr_lo_r};

  assign wb_wr_en = wr_ok && (sfr_addr_i == `IAPF_OFF_D0H);
  assign wb_wr_idx = addr_lo_r[4:0];
  assign wb_wr_data = {sfr_wdata_i, dlo_r[0]};
  assign wb_clr = bclr_r || (prog_done && (mode_r == iapf_pkg::MODE_WRITE));

  assign unl_if.start = ctrl_wr && sfr_wdata_i[`IAPF_CTRL_TRIG];
  assign unl_if.mode_ok = (mode_r == iapf_pkg::MODE_UNLOCK);
  assign unl_if.w1 = {dhi_r[1], dlo_r[1]};
  assign unl_if.w2 = {dhi_r[2], dlo_r[2]};
  assign unl_if.w3 = {dhi_r[3], dlo_r[3]};
  assign unl_done = unl_if.done;
  assign unl_pass = unl_if.pass;

  // ************************************************
  // Submodules
  // ************************************************
  iapf_unlock #(
    .CYCLES(UNLOCK_CYCLES)
  ) u_unlock (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .u(unl_if.tmr)
  );

  iapf_wbuf u_wbuf (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .wr_en_i(wb_wr_en),
    .wr_idx_i(wb_wr_idx),
    .wr_data_i(wb_wr_data),
    .clr_i(wb_clr),
    .rd_idx_i(flash_wbuf_idx_i),
    .rd_data_o(flash_wbuf_data_o)
  );

  // ************************************************
  // Control register
  // ************************************************
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ew_en_r <= 1'b0;
      mode_r <= 3'h0;
      trig_r <= 1'b0;
      wi_r <= 1'b0;
      re_r <= 1'b0;
      ri_r <= 1'b0;
    end else begin
      // Hardware set wins over a software clear in the same cycle
      if (unl_pass) begin
        ew_en_r <= 1'b1;
      end else if (ctrl_wr && !sfr_wdata_i[`IAPF_CTRL_EWEN]) begin
        ew_en_r <= 1'b0;
      end
      if (ctrl_wr) begin
        mode_r <= sfr_wdata_i[`IAPF_CTRL_MODE_MSB:`IAPF_CTRL_MODE_LSB];
        re_r <= sfr_wdata_i[`IAPF_CTRL_RE];
      end
      if (unl_if.start) begin
        trig_r <= 1'b1;
      end else if (unl_done) begin
        trig_r <= 1'b0;
      end
      // Both initiates refused on the forbidden combined write
      if (ctrl_wr && sfr_wdata_i[`IAPF_CTRL_WI] && !triple) begin
        wi_r <= 1'b1;
      end else if (drop_wi || prog_done) begin
        wi_r <= 1'b0;
      end
      if (ctrl_wr && sfr_wdata_i[`IAPF_CTRL_RI] && !triple) begin
        ri_r <= 1'b1;
      end else if (drop_ri || read_done) begin
        ri_r <= 1'b0;
      end
    end
  end

  // ************************************************
  // Buffer clear register
  // ************************************************
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bclr_r <= 1'b0;
      bclr_rsv7_r <= 1'b0;
      bclr_rsv4_r <= 1'b0;
    end else if (wr_ok && (sfr_addr_i == `IAPF_OFF_BCLR)) begin
      bclr_r <= sfr_wdata_i[`IAPF_BCLR_TRIG] || bclr_r;
      bclr_rsv7_r <= sfr_wdata_i[`IAPF_BCLR_RSV7];
      bclr_rsv4_r <= sfr_wdata_i[`IAPF_BCLR_RSV4];
    end else begin
      bclr_r <= 1'b0;
    end
  end

  // ************************************************
  // Address pair
  // ************************************************
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      addr_lo_r <= `IAPF_RST_BYTE;
      addr_hi_r <= 5'h00;
    end else if (wr_ok && (sfr_addr_i == `IAPF_OFF_ADDR_LOW)) begin
      addr_lo_r <= sfr_wdata_i;
    end else if (wr_ok && (sfr_addr_i == `IAPF_OFF_ADDR_HIGH)) begin
      addr_hi_r <= sfr_wdata_i[4:0];
    end else if (wb_wr_en && (addr_lo_r[4:0] != `IAPF_PAGE_LAST)) begin
      {addr_hi_r, addr_lo_r} <= 13'(word_addr + 13'h0001);
    end
  end

  // ************************************************
  // Data registers
  // ************************************************
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < 4; i++) begin
        dlo_r[i] <= `IAPF_RST_BYTE;
        dhi_r[i] <= `IAPF_RST_BYTE;
      end
    end else if (read_done) begin
      dlo_r[0] <= flash_rdata_i[7:0];
      dhi_r[0] <= flash_rdata_i[15:8];
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (wr_ok && (sfr_addr_i == 4'(`IAPF_OFF_D0L + 2 * i))) begin
          dlo_r[i] <= sfr_wdata_i;
        end
        if (wr_ok && (sfr_addr_i == 4'(`IAPF_OFF_D0H + 2 * i))) begin
          dhi_r[i] <= sfr_wdata_i;
        end
      end
    end
  end

  // ************************************************
  // Operation sequencer
  // ************************************************
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= iapf_pkg::ST_IDLE;
      op_cnt_r <= '0;
      cpu_stall_o <= 1'b0;
      flash_start_o <= 1'b0;
      flash_mode_o <= 3'h0;
      flash_addr_o <= 13'h0000;
    end else begin
      flash_start_o <= go_prog || go_read;
      op_cnt_r <= op_cnt_r + iapf_pkg::iapf_cnt_t'(1);
      unique case (state_r)
        iapf_pkg::ST_IDLE: begin
          op_cnt_r <= '0;
          if (go_prog || go_read) begin
            state_r <= go_prog ? iapf_pkg::ST_PROG : iapf_pkg::ST_READ;
            cpu_stall_o <= 1'b1;
            flash_mode_o <= mode_r;
            flash_addr_o <= word_addr;
          end
        end
        iapf_pkg::ST_PROG: begin
          if (prog_done) begin
            state_r <= iapf_pkg::ST_IDLE;
            cpu_stall_o <= 1'b0;
          end
        end
        iapf_pkg::ST_READ: begin
          if (read_done) begin
            state_r <= iapf_pkg::ST_IDLE;
            cpu_stall_o <= 1'b0;
          end
        end
        default: begin
          state_r <= iapf_pkg::ST_IDLE;
          cpu_stall_o <= 1'b0;
        end
      endcase
    end
  end

  // ************************************************
  // Read data
  // ************************************************
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sfr_rdata_o <= 8'h00;
    end else if (sfr_rd_i) begin
      unique case (sfr_addr_i)
        `IAPF_OFF_ADDR_LOW: sfr_rdata_o <= addr_lo_r;
        `IAPF_OFF_ADDR_HIGH: sfr_rdata_o <= {3'h0, addr_hi_r} & `IAPF_ADDR_HIGH_MASK;
        `IAPF_OFF_D0L: sfr_rdata_o <= dlo_r[0];
        `IAPF_OFF_D0H: sfr_rdata_o <= dhi_r[0];
        `IAPF_OFF_D1L: sfr_rdata_o <= dlo_r[1];
        `IAPF_OFF_D1H: sfr_rdata_o <= dhi_r[1];
        `IAPF_OFF_D2L: sfr_rdata_o <= dlo_r[2];
        `IAPF_OFF_D2H: sfr_rdata_o <= dhi_r[2];
        `IAPF_OFF_D3L: sfr_rdata_o <= dlo_r[3];
        `IAPF_OFF_D3H: sfr_rdata_o <= dhi_r[3];
        `IAPF_OFF_CTRL: sfr_rdata_o <= {ew_en_r, mode_r, trig_r, wi_r, re_r, ri_r};
        `IAPF_OFF_BCLR: sfr_rdata_o <= {bclr_rsv7_r, 2'b00, bclr_rsv4_r, 3'b000, bclr_r};
        default: sfr_rdata_o <= 8'h00;
      endcase
    end
  end

  // ************************************************
  // Checks
  // ************************************************
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  addr_hi_rsv_a: assert property (sfr_rd_i && (sfr_addr_i == `IAPF_OFF_ADDR_HIGH) |=> sfr_rdata_o[7:5] == 3'h0)
    else $error("address high upper bits not zero");
  low_no_load_a: assert property (wr_ok && (sfr_addr_i == `IAPF_OFF_D0L) |-> !wb_wr_en)
    else $error("low byte write loaded the buffer");
  high_load_a: assert property (wr_ok && (sfr_addr_i == `IAPF_OFF_D0H) && !wb_clr |->
    wb_wr_en ##1 (u_wbuf.mem_r[$past(addr_lo_r[4:0])] == {$past(sfr_wdata_i), $past(dlo_r[0])}))
    else $error("high byte write did not load the word");
  addr_inc_a: assert property (wb_wr_en && (addr_lo_r[4:0] != 5'h1F) |=> word_addr == $past(word_addr) + 13'h0001)
    else $error("address not incremented after load");
  page_stop_a: assert property (wb_wr_en && (addr_lo_r[4:0] == 5'h1F) |=> $stable(word_addr))
    else $error("address crossed the page end");
  ew_set_src_a: assert property ($rose(ew_en_r) |-> $past(unl_pass))
    else $error("enable bit set without unlock");
  ew_clear_a: assert property (ctrl_wr && !sfr_wdata_i[7] && !unl_pass |=> !ew_en_r && !allow_w)
    else $error("enable bit not cleared at once");
  trig_clear_a: assert property (unl_done && !unl_if.start |=> !trig_r)
    else $error("unlock trigger not cleared at expiry");
  read_block_a: assert property (drop_ri |=> (state_r == iapf_pkg::ST_IDLE) && !ri_r && !cpu_stall_o)
    else $error("read ran while not enabled");
  read_len_a: assert property (go_read |=> (ri_r && cpu_stall_o)[*4] ##1 !ri_r)
    else $error("read initiate length wrong");
  prog_hold_a: assert property ((state_r == iapf_pkg::ST_PROG) |-> wi_r && cpu_stall_o)
    else $error("program not holding initiate and stall");
  auto_clr_a: assert property (prog_done && (mode_r == iapf_pkg::MODE_WRITE) |->
    wb_clr ##1 (!wi_r && (u_wbuf.mem_r[0] == 16'h0000) && (u_wbuf.mem_r[31] == 16'h0000)))
    else $error("buffer not cleared after write");
endmodule

/* hdl/iapf_regs.svh */
// Purpose: Offsets, field positions, reset values and timing counts of the IAP flash control block
// Assumes: 100 MHz core clock, 8-bit special function register port
// Notes: Offsets are indices on the local register port
`ifndef IAPF_REGS_SVH
`define IAPF_REGS_SVH

// ************************************************
// Register offsets
// ************************************************
`define IAPF_OFF_ADDR_LOW 4'h0
`define IAPF_OFF_ADDR_HIGH 4'h1
`define IAPF_OFF_D0L 4'h2
`define IAPF_OFF_D0H 4'h3
`define IAPF_OFF_D1L 4'h4
`define IAPF_OFF_D1H 4'h5
`define IAPF_OFF_D2L 4'h6
`define IAPF_OFF_D2H 4'h7
`define IAPF_OFF_D3L 4'h8
`define IAPF_OFF_D3H 4'h9
`define IAPF_OFF_CTRL 4'hA
`define IAPF_OFF_BCLR 4'hB

// ************************************************
// Field positions and reset values
// ************************************************
`define IAPF_CTRL_EWEN 7
`define IAPF_CTRL_MODE_MSB 6
`define IAPF_CTRL_MODE_LSB 4
`define IAPF_CTRL_TRIG 3
`define IAPF_CTRL_WI 2
`define IAPF_CTRL_RE 1
`define IAPF_CTRL_RI 0
`define IAPF_BCLR_RSV7 7
`define IAPF_BCLR_RSV4 4
`define IAPF_BCLR_TRIG 0
`define IAPF_ADDR_HIGH_MASK 8'h1F
`define IAPF_PAGE_LAST 5'h1F
`define IAPF_RST_BYTE 8'h00

// ************************************************
// Unlock pattern, words 1 to 3 as {high, low}
// ************************************************
`define IAPF_PAT_W1 16'h0400
`define IAPF_PAT_W2 16'h090D
`define IAPF_PAT_W3 16'h40C3

// ************************************************
// Timing
// ************************************************
`define IAPF_CLK_MHZ 100
`define IAPF_UNLOCK_TIME_US 1000
`define IAPF_UNLOCK_CYCLES (`IAPF_UNLOCK_TIME_US * `IAPF_CLK_MHZ)
`define IAPF_PROG_TIME_US 2200
`define IAPF_PROG_CYCLES (`IAPF_PROG_TIME_US * `IAPF_CLK_MHZ)
`define IAPF_READ_TIME_NS 40
`define IAPF_READ_CYCLES ((`IAPF_READ_TIME_NS * `IAPF_CLK_MHZ + 999) / 1000)

`endif

/* hdl/iapf_pkg.sv */
// Purpose: Types of the IAP flash control block
// Assumes: Constants live in iapf_regs.svh
// Notes: Reserved mode codes have no enum member
package iapf_pkg;
  typedef enum logic [2:0] {
    MODE_WRITE = 3'h0,
    MODE_ERASE = 3'h1,
    MODE_READ = 3'h3,
    MODE_UNLOCK = 3'h6
  } iapf_mode_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PROG = 2'b01,
    ST_READ = 2'b11
  } iapf_state_e;

  typedef logic [19:0] iapf_cnt_t;
endpackage

/* hdl/iapf_unlock_if.sv */
// Purpose: Link between the control logic and the unlock timer
// Assumes: Single core clock
// Notes: done and pass are one-cycle pulses
`timescale 1ns/1ps
interface iapf_unlock_if;
  logic start;
  logic mode_ok;
  logic [15:0] w1;
  logic [15:0] w2;
  logic [15:0] w3;
  logic done;
  logic pass;
  modport ctl (output start, output mode_ok, output w1, output w2, output w3, input done, input pass);
  modport tmr (input start, input mode_ok, input w1, input w2, input w3, output done, output pass);
endinterface

/* hdl/iapf_unlock.sv */
// Purpose: Unlock window timer and pattern check
// Assumes: Pattern words come from live data registers
// Notes: A new start restarts the window
`timescale 1ns/1ps
`include "iapf_regs.svh"
module iapf_unlock #(
  parameter int unsigned CYCLES = `IAPF_UNLOCK_CYCLES
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Control side
  iapf_unlock_if.tmr u
);
  iapf_pkg::iapf_cnt_t cnt_r;
  logic run_r;
  logic last;
  logic match;

  assign last = run_r && (cnt_r == iapf_pkg::iapf_cnt_t'(CYCLES - 1));
  assign match = (u.w1 == `IAPF_PAT_W1) && (u.w2 == `IAPF_PAT_W2) && (u.w3 == `IAPF_PAT_W3);

  // ************************************************
  // Window timer
  // ************************************************
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= '0;
      run_r <= 1'b0;
    end else if (u.start) begin
      cnt_r <= '0;
      run_r <= 1'b1;
    end else if (last) begin
      run_r <= 1'b0;
    end else if (run_r) begin
      cnt_r <= cnt_r + iapf_pkg::iapf_cnt_t'(1);
    end
  end

  // ************************************************
  // Verdict at expiry
  // ************************************************
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      u.done <= 1'b0;
      u.pass <= 1'b0;
    end else begin
      u.done <= last && !u.start;
      u.pass <= last && !u.start && match && u.mode_ok;
    end
  end

  pass_pattern_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    u.pass |-> u.done && $past(match) && $past(run_r))
    else $error("unlock passed without correct pattern");
endmodule

/* hdl/iapf_wbuf.sv */
// Purpose: 32-word write buffer
// Assumes: Clear and load never in the same cycle by intent; clear wins
// Notes: Flop array so the whole buffer clears in one cycle
`timescale 1ns/1ps
module iapf_wbuf (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Load and clear
  input wire logic wr_en_i,
  input wire logic [4:0] wr_idx_i,
  input wire logic [15:0] wr_data_i,
  input wire logic clr_i,
  // Flash side read
  input wire logic [4:0] rd_idx_i,
  output logic [15:0] rd_data_o
);
  logic [15:0] mem_r [32];

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < 32; i++) begin
        mem_r[i] <= 16'h0000;
      end
    end else if (clr_i) begin
      for (int i = 0; i < 32; i++) begin
        mem_r[i] <= 16'h0000;
      end
    end else if (wr_en_i) begin
      mem_r[wr_idx_i] <= wr_data_i;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_data_o <= 16'h0000;
    end else begin
      rd_data_o <= mem_r[rd_idx_i];
    end
  end
endmodule

/* dv/iap_flash_program_control_tb.sv */
// Purpose: Self-checking bench for the IAP flash control registers and sequencer
// Assumes: Short unlock and program counts; register port driven on the falling edge
// Notes: Flash read data is a fixed word; the buffer is checked through its read-out port
`timescale 1ns/1ps
`include "iapf_regs.svh"
// ************************************************
// Bench
// ************************************************
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin err_total++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module iap_flash_program_control_tb;
  localparam int unsigned UNL = 20;
  localparam int unsigned PRG = 10;
  // Long enough for every scenario, short enough to cut a hang quickly
  localparam int LIMIT = 3000;
  localparam logic [15:0] FLASH_WORD = 16'hC35A;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] sfr_addr_i = 4'h0;
  logic sfr_wr_i = 1'b0;
  logic sfr_rd_i = 1'b0;
  logic [7:0] sfr_wdata_i = 8'h00;
  logic [7:0] sfr_rdata_o;
  logic cpu_stall_o;
  logic flash_start_o;
  logic [2:0] flash_mode_o;
  logic [12:0] flash_addr_o;
  logic [15:0] flash_rdata_i = FLASH_WORD;
  logic [4:0] flash_wbuf_idx_i = 5'h00;
  logic [15:0] flash_wbuf_data_o;
  int err_total = 0;
  int checks = 0;
  int cyc = 0;
  int n;
  iapf_top #(.UNLOCK_CYCLES(UNL), .PROG_CYCLES(PRG)) uut (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .sfr_addr_i(sfr_addr_i),
    .sfr_wr_i(sfr_wr_i),
    .sfr_rd_i(sfr_rd_i),
    .sfr_wdata_i(sfr_wdata_i),
    .sfr_rdata_o(sfr_rdata_o),
    .cpu_stall_o(cpu_stall_o),
    .flash_start_o(flash_start_o),
    .flash_mode_o(flash_mode_o),
    .flash_addr_o(flash_addr_o),
    .flash_rdata_i(flash_rdata_i),
    .flash_wbuf_idx_i(flash_wbuf_idx_i),
    .flash_wbuf_data_o(flash_wbuf_data_o)
  );
  always #5 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_total++;
      wrap_up();
    end
  end
  // ************************************************
  // Port tasks
  // ************************************************
  // wr, rdc and bufc each start on a fresh falling edge so no strobe is assigned twice in one step
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge core_clk_i);
    sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_wr_i = 1'b1;
    @(negedge core_clk_i);
    sfr_wr_i = 1'b0;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] e, input string nm);
    @(negedge core_clk_i);
    sfr_addr_i = a;
    sfr_rd_i = 1'b1;
    @(negedge core_clk_i);
    sfr_rd_i = 1'b0;
    `CHK(nm, e, sfr_rdata_o)
  endtask
  task automatic bufc(input logic [4:0] i, input logic [15:0] e);
    @(negedge core_clk_i);
    flash_wbuf_idx_i = i;
    repeat (2) @(negedge core_clk_i);
    `CHK("buffer word", e, flash_wbuf_data_o)
  endtask
  // Counts falling edges until the stall is low, bounded; an unknown stall counts as high
  task automatic stall_len(output int c);
    c = 0;
    while (cpu_stall_o !== 1'b0 && c < 100) begin
      c++;
      @(negedge core_clk_i);
    end
  endtask
  // ************************************************
  // Scenarios
  // ************************************************
  task automatic t_regs();
    for (int i = 0; i < 13; i++) rdc(i[3:0], 8'h00, "reset value");
    wr(`IAPF_OFF_ADDR_HIGH, 8'hFF);
    rdc(`IAPF_OFF_ADDR_HIGH, 8'h1F, "addr high");
    for (int i = 4; i < 10; i++) wr(i[3:0], 8'hA0 + i[7:0]);
    for (int i = 4; i < 10; i++) rdc(i[3:0], 8'hA0 + i[7:0], "data word");
    wr(`IAPF_OFF_CTRL, 8'h80);
    rdc(`IAPF_OFF_CTRL, 8'h00, "enable set by sw");
    $display("t_regs done");
  endtask
  task automatic t_unlock();
    wr(`IAPF_OFF_CTRL, 8'h68);
    rdc(`IAPF_OFF_CTRL, 8'h68, "trigger running");
    repeat (UNL + 5) @(negedge core_clk_i);
    rdc(`IAPF_OFF_CTRL, 8'h60, "bad pattern");
    wr(`IAPF_OFF_CTRL, 8'h68);
    wr(`IAPF_OFF_D1L, 8'h00);
    wr(`IAPF_OFF_D1H, 8'h04);
    wr(`IAPF_OFF_D2L, 8'h0D);
    wr(`IAPF_OFF_D2H, 8'h09);
    wr(`IAPF_OFF_D3L, 8'hC3);
    wr(`IAPF_OFF_D3H, 8'h40);
    repeat (UNL) @(negedge core_clk_i);
    rdc(`IAPF_OFF_CTRL, 8'hE0, "unlocked");
    $display("t_unlock done");
  endtask
  task automatic t_load();
    wr(`IAPF_OFF_ADDR_HIGH, 8'h02);
    wr(`IAPF_OFF_ADDR_LOW, 8'h1E);
    wr(`IAPF_OFF_D0L, 8'h34);
    bufc(5'h1E, 16'h0000);
    wr(`IAPF_OFF_D0H, 8'h12);
    bufc(5'h1E, 16'h1234);
    rdc(`IAPF_OFF_ADDR_LOW, 8'h1F, "addr step");
    wr(`IAPF_OFF_D0L, 8'h78);
    wr(`IAPF_OFF_D0H, 8'h56);
    bufc(5'h1F, 16'h5678);
    rdc(`IAPF_OFF_ADDR_LOW, 8'h1F, "page end");
    $display("t_load done");
  endtask
  task automatic t_prog(input logic [7:0] cv, input logic [2:0] m);
    wr(`IAPF_OFF_CTRL, cv);
    @(negedge core_clk_i);
    `CHK("start pulse", 1'b1, flash_start_o)
    `CHK("mode out", m, flash_mode_o)
    `CHK("addr out", 13'h021F, flash_addr_o)
    stall_len(n);
    `CHK("program stall", PRG, n)
    rdc(`IAPF_OFF_CTRL, cv & 8'hFB, "initiate cleared");
    $display("t_prog done");
  endtask
  task automatic t_locked();
    wr(`IAPF_OFF_CTRL, 8'hA4);
    @(negedge core_clk_i);
    `CHK("reserved start", 1'b0, flash_start_o)
    stall_len(n);
    `CHK("reserved stall", 0, n)
    rdc(`IAPF_OFF_CTRL, 8'hA0, "reserved mode");
    wr(`IAPF_OFF_CTRL, 8'h10);
    rdc(`IAPF_OFF_CTRL, 8'h10, "enable cleared");
    wr(`IAPF_OFF_CTRL, 8'h14);
    @(negedge core_clk_i);
    `CHK("locked start", 1'b0, flash_start_o)
    stall_len(n);
    `CHK("locked stall", 0, n)
    rdc(`IAPF_OFF_CTRL, 8'h10, "locked initiate");
    $display("t_locked done");
  endtask
  task automatic t_read();
    wr(`IAPF_OFF_CTRL, 8'h33);
    @(negedge core_clk_i);
    stall_len(n);
    `CHK("read stall", 4, n)
    rdc(`IAPF_OFF_D0L, FLASH_WORD[7:0], "read low");
    rdc(`IAPF_OFF_D0H, FLASH_WORD[15:8], "read high");
    rdc(`IAPF_OFF_CTRL, 8'h32, "read done");
    wr(`IAPF_OFF_CTRL, 8'h31);
    @(negedge core_clk_i);
    `CHK("read no start", 1'b0, flash_start_o)
    stall_len(n);
    `CHK("read blocked", 0, n)
    rdc(`IAPF_OFF_CTRL, 8'h30, "blocked initiate");
    wr(`IAPF_OFF_CTRL, 8'h37);
    @(negedge core_clk_i);
    `CHK("three no start", 1'b0, flash_start_o)
    stall_len(n);
    `CHK("all three set", 0, n)
    rdc(`IAPF_OFF_CTRL, 8'h32, "all three value");
    $display("t_read done");
  endtask
  task automatic t_bclr();
    wr(`IAPF_OFF_ADDR_LOW, 8'h00);
    wr(`IAPF_OFF_D0H, 8'h9E);
    bufc(5'h00, {8'h9E, FLASH_WORD[7:0]});
    wr(`IAPF_OFF_BCLR, 8'h91);
    repeat (3) @(negedge core_clk_i);
    rdc(`IAPF_OFF_BCLR, 8'h90, "clear done");
    bufc(5'h00, 16'h0000);
    wr(`IAPF_OFF_BCLR, 8'hEE);
    rdc(`IAPF_OFF_BCLR, 8'h80, "clear reg bits");
    $display("t_bclr done");
  endtask
  // ************************************************
  // Run and verdict
  // ************************************************
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge core_clk_i);
    rst_i = 1'b0;
    t_regs();
    t_unlock();
    t_load();
    t_prog(8'h94, 3'h1);
    bufc(5'h1F, 16'h5678);
    t_prog(8'h84, 3'h0);
    bufc(5'h1E, 16'h0000);
    t_locked();
    t_read();
    t_bclr();
    wrap_up();
  end
endmodule
